/* logic/sram_pkg.sv */
package sram_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int LOW_W = 2;
  localparam int HI_W = 17;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = 9;
  localparam int DATA_W = 32;
  localparam int WORD_W = 36;
  localparam int DEPTH = 524288;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic [1:0] LOW_RST = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [16:0] HI_RST = 17'h0;
  localparam logic [18:0] ADDR_RST = 19'h0;
  localparam logic [35:0] WORD_RST = 36'h0;

  typedef enum logic [2:0] {
    ST_DESEL = 3'b001,
    ST_PS_FIRST = 3'b010,
    ST_ACTIVE = 3'b100
  } access_state_t;
endpackage

/* logic/burst_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface burst_if;
  logic load;
  logic advance;
  logic inter;
  logic [1:0] start_low;
  logic [1:0] cur_low;
  logic [1:0] nxt_low;
  modport ctl (output load, output advance, output inter, output start_low,
               input cur_low, input nxt_low);
  modport cnt (input load, input advance, input inter, input start_low,
               output cur_low, output nxt_low);
endinterface
`default_nettype wire

/* logic/burst_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module burst_counter (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Counter control
  burst_if.cnt bus
);
  logic [1:0] base_q;
  logic [1:0] count_q;

  function automatic logic [1:0] seq_low(input logic [1:0] base, input logic [1:0] cnt,
                                         input logic inter);
    seq_low = inter ? (base ^ cnt) : 2'(base + cnt);
  endfunction

  // ---------------------------------------------------------------
  // Wraparound counter
  // ---------------------------------------------------------------
  // hold start, count
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_q <= sram_pkg::LOW_RST;
      count_q <= sram_pkg::LOW_RST;
    end else if (bus.load) begin
      base_q <= bus.start_low;
      count_q <= sram_pkg::LOW_RST;
    end else if (bus.advance) begin
      count_q <= 2'(count_q + sram_pkg::STEP_ONE);
    end
  end

  assign bus.cur_low = seq_low(base_q, count_q, bus.inter);
  assign bus.nxt_low = seq_low(base_q, 2'(count_q + sram_pkg::STEP_ONE), bus.inter);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence adv_only_s;
    bus.advance && !bus.load;
  endsequence

  burst_wrap_a: assert property (
    bus.load ##1 adv_only_s [*4] |=> bus.cur_low == $past(bus.start_low, 5))
    else $error("burst did not wrap after four steps");

  linear_step_a: assert property (
    adv_only_s ##0 !bus.inter |=> bus.cur_low == 2'($past(bus.cur_low) + 2'h1))
    else $error("linear step is not plus one");

  inter_step_a: assert property (
    bus.load && bus.inter ##1 adv_only_s |=> bus.cur_low == ($past(bus.start_low, 2) ^ 2'h1))
    else $error("interleaved second address wrong");
endmodule
`default_nettype wire

/* logic/pipelined_burst_sram_access.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - data inputs captured at clock rise
// - read data follows address by one cycle
// - output enable low drives, high releases
// - strap low linear, high interleaved
// - two-bit counter generates burst addresses
// - burst steps only on advance input
// - global write writes all lanes
// - byte write updates selected lanes only
// - processor strobe ignored when select A high
// - strobe, selected, no write starts read
// - new access loads address and counter
// - read data leaves output register next rise
// - first cycle from deselect stays released
// - deselect releases outputs at once
// - processor-strobe start ignores write, advance
// - processor-strobe write completes second rise
// - second cycle uses byte-write controls
// - detected write forces drivers off
// - both strobes low, processor strobe wins if select A low
// - advance low steps counter
// - interleaved order xors a count
// - linear order adds one modulo four
module pipelined_burst_sram_access (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Address and strobes
  input wire logic [sram_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_burst_advance_n,
  // Chip selects
  input wire logic i_chip_sel_a_n,
  input wire logic i_chip_sel_b,
  input wire logic i_chip_sel_c_n,
  // Write controls
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic [sram_pkg::LANES-1:0] i_byte_lane_select_n,
  // Output enable and burst-order strap
  input wire logic i_out_enable_n,
  input wire logic i_burst_order,
  // Data and parity lines
  input wire logic [sram_pkg::DATA_W-1:0] i_data,
  output logic [sram_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe,
  input wire logic [sram_pkg::LANES-1:0] i_parity_lines,
  output logic [sram_pkg::LANES-1:0] o_parity_lines,
  output logic o_parity_oe
);

  // ---------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------
  logic [sram_pkg::WORD_W-1:0] mem [sram_pkg::DEPTH];

  sram_pkg::access_state_t state_q;
  sram_pkg::access_state_t state_d;
  logic [sram_pkg::HI_W-1:0] addr_hi_q;
  logic [sram_pkg::ADDR_W-1:0] rd_addr_q;
  logic rd_pend_q;
  logic [sram_pkg::WORD_W-1:0] out_q;
  logic out_valid_q;

  burst_if burst ();

  burst_counter u_counter (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .bus(burst.cnt)
  );

  // ---------------------------------------------------------------
  // Lane packing
  // ---------------------------------------------------------------
  // Lane i keeps data byte i in its low bits and parity bit i on top
  function automatic logic [sram_pkg::WORD_W-1:0] pack_word(
      input logic [sram_pkg::DATA_W-1:0] data, input logic [sram_pkg::LANES-1:0] par);
    logic [sram_pkg::WORD_W-1:0] w;
    w = sram_pkg::WORD_RST;
    for (int i = 0; i < sram_pkg::LANES; i++) begin
      w[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] = {par[i], data[i*sram_pkg::BYTE_W +: 8]};
    end
    pack_word = w;
  endfunction

  function automatic logic [sram_pkg::DATA_W-1:0] word_data(
      input logic [sram_pkg::WORD_W-1:0] w);
    logic [sram_pkg::DATA_W-1:0] d;
    d = 32'h0;
    for (int i = 0; i < sram_pkg::LANES; i++) begin
      d[i*sram_pkg::BYTE_W +: 8] = w[i*sram_pkg::LANE_W +: 8];
    end
    word_data = d;
  endfunction

  function automatic logic [sram_pkg::LANES-1:0] word_par(input logic [sram_pkg::WORD_W-1:0] w);
    logic [sram_pkg::LANES-1:0] p;
    p = 4'h0;
    for (int i = 0; i < sram_pkg::LANES; i++) begin
      p[i] = w[i*sram_pkg::LANE_W + sram_pkg::BYTE_W];
    end
    word_par = p;
  endfunction

  // ---------------------------------------------------------------
  // Cycle decode
  // ---------------------------------------------------------------
  logic selected;
  logic ps_take;
  logic cs_take;
  logic new_addr;
  logic start;
  logic desel;
  logic cont;
  logic [sram_pkg::LANES-1:0] lane_we;
  logic wr_now;
  logic step;
  logic [sram_pkg::ADDR_W-1:0] cur_addr;
  logic [sram_pkg::ADDR_W-1:0] acc_addr;
  logic rd_now;
  logic [sram_pkg::WORD_W-1:0] wr_word;

  assign selected = !i_chip_sel_a_n && i_chip_sel_b && !i_chip_sel_c_n;

  // select A gates the processor strobe
  assign ps_take = !i_processor_addr_strobe_n && !i_chip_sel_a_n;
  // controller strobe only if processor strobe not taken
  assign cs_take = !i_controller_addr_strobe_n && !ps_take;
  assign new_addr = ps_take || cs_take;
  assign start = new_addr && selected;
  // a strobe with inactive selects ends the access
  assign desel = new_addr && !selected;
  assign cont = (state_q != sram_pkg::ST_DESEL) && !new_addr;

  // byte write needs enable plus lane select
  always_comb begin
    if (!i_global_write_n) begin
      lane_we = '1;
    end else if (!i_byte_write_enable_n) begin
      lane_we = ~i_byte_lane_select_n;
    end else begin
      lane_we = '0;
    end
  end

  // write controls only count after the start cycle
  assign wr_now = cont && (|lane_we);
  // counter moves only on advance in a running burst
  // advance low steps to the next address
  assign step = (state_q == sram_pkg::ST_ACTIVE) && cont && !i_burst_advance_n;

  // upper bits held, low pair from counter
  assign cur_addr = {addr_hi_q, burst.cur_low};
  assign acc_addr = step ? {addr_hi_q, burst.nxt_low} : cur_addr;

  // read on every start, or in a running access with no write
  assign rd_now = start || (cont && !(|lane_we));
  assign wr_word = pack_word(i_data, i_parity_lines);

  // ---------------------------------------------------------------
  // Burst counter control
  // ---------------------------------------------------------------
  // strap low picks linear order
  assign burst.inter = (i_burst_order != sram_pkg::ORDER_LINEAR);
  // load the low pair on every new access
  assign burst.load = start;
  assign burst.start_low = i_addr[sram_pkg::LOW_W-1:0];
  assign burst.advance = step;

  // ---------------------------------------------------------------
  // Access state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (start) begin
      state_d = ps_take ? sram_pkg::ST_PS_FIRST : sram_pkg::ST_ACTIVE;
    end else if (desel) begin
      state_d = sram_pkg::ST_DESEL;
    end else begin
      unique case (state_q)
        sram_pkg::ST_DESEL: begin
          state_d = sram_pkg::ST_DESEL;
        end
        sram_pkg::ST_PS_FIRST: begin
          state_d = sram_pkg::ST_ACTIVE;
        end
        sram_pkg::ST_ACTIVE: begin
          state_d = sram_pkg::ST_ACTIVE;
        end
        default: begin
          state_d = sram_pkg::ST_DESEL;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= sram_pkg::ST_DESEL;
    end else begin
      state_q <= state_d;
    end
  end

  // address register takes the sampled address
  // only a new access changes the upper bits
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_hi_q <= sram_pkg::HI_RST;
    end else if (start) begin
      addr_hi_q <= i_addr[sram_pkg::ADDR_W-1:sram_pkg::LOW_W];
    end
  end

  // ---------------------------------------------------------------
  // Array write
  // ---------------------------------------------------------------
  // Self-timed write: array updated at the same rise the data is taken
  // data lines captured at clock rise
  // processor-strobe write lands on second rise
  always_ff @(posedge i_sys_clk) begin
    if (i_rst_b && wr_now) begin
      for (int i = 0; i < sram_pkg::LANES; i++) begin
        if (lane_we[i]) begin
          mem[acc_addr][i*sram_pkg::LANE_W +: sram_pkg::LANE_W] <=
            wr_word[i*sram_pkg::LANE_W +: sram_pkg::LANE_W];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read pipeline
  // ---------------------------------------------------------------
  // address stage of the read
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_addr_q <= sram_pkg::ADDR_RST;
      rd_pend_q <= 1'b0;
    end else begin
      rd_addr_q <= start ? i_addr : acc_addr;
      rd_pend_q <= rd_now;
    end
  end

  // output register loads one rise after the address
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_q <= sram_pkg::WORD_RST;
    end else if (rd_pend_q) begin
      out_q <= mem[rd_addr_q];
    end
  end

  // Valid tracks whether the output register holds read data worth driving
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_valid_q <= 1'b0;
    end else if (desel || wr_now) begin
      // deselect drops drive at this rise
      // a write cancels pending read data
      out_valid_q <= 1'b0;
    end else if (start && state_q == sram_pkg::ST_DESEL) begin
      // nothing driven in the first cycle out of deselect
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= rd_pend_q;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // Output enable is asynchronous, so it gates the drive directly
  // drive only while output enable is low
  assign o_data_oe = out_valid_q && !i_out_enable_n;
  assign o_parity_oe = out_valid_q && !i_out_enable_n;
  assign o_data = word_data(out_q);
  assign o_parity_lines = word_par(out_q);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  logic [sram_pkg::WORD_W-1:0] rd_word;
  assign rd_word = mem[rd_addr_q];

  sequence ps_start_s;
    ps_take && selected;
  endsequence

  sequence ps_write_s;
    ps_start_s ##1 (!new_addr && !i_global_write_n);
  endsequence

  read_latency_a: assert property (
    rd_pend_q |=> out_q === $past(rd_word))
    else $error("read data not from previous address");

  oe_gate_a: assert property (
    i_out_enable_n |-> !o_data_oe && !o_parity_oe)
    else $error("drivers on while output enable high");

  global_write_a: assert property (
    ps_write_s |=> mem[$past(acc_addr)] == $past(wr_word))
    else $error("global write did not store whole word");

  byte_keep_a: assert property (
    wr_now && i_global_write_n && i_byte_lane_select_n[0]
      |=> mem[$past(acc_addr)][8:0] == $past(mem[acc_addr][8:0]))
    else $error("unselected lane was changed");

  strobe_gate_a: assert property (
    !i_processor_addr_strobe_n && i_chip_sel_a_n && i_controller_addr_strobe_n
      && state_q == sram_pkg::ST_DESEL |=> state_q == sram_pkg::ST_DESEL)
    else $error("processor strobe honoured with select A high");

  desel_release_a: assert property (
    desel |=> !o_data_oe [*2])
    else $error("outputs driven after deselect");

  first_mask_a: assert property (
    start && state_q == sram_pkg::ST_DESEL |=> !o_data_oe)
    else $error("output driven in first cycle from deselect");

  write_off_a: assert property (
    wr_now |=> !o_data_oe)
    else $error("drivers on after write");

  ps_first_a: assert property (
    ps_start_s |=> state_q == sram_pkg::ST_PS_FIRST && !step)
    else $error("processor-strobe start did not hold first cycle");

  upper_hold_a: assert property (
    !start |=> addr_hi_q == $past(addr_hi_q))
    else $error("upper address moved inside burst");

  strobe_prio_a: assert property (
    !i_processor_addr_strobe_n && !i_controller_addr_strobe_n && start
      && !i_chip_sel_a_n |=> state_q == sram_pkg::ST_PS_FIRST)
    else $error("controller strobe taken over processor strobe");
endmodule
`default_nettype wire

/* dv/bus_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  // Clock
  input wire logic i_sys_clk,
  // Address, strobes and selects
  output logic [sram_pkg::ADDR_W-1:0] o_addr,
  output logic o_processor_addr_strobe_n,
  output logic o_controller_addr_strobe_n,
  output logic o_burst_advance_n,
  output logic o_chip_sel_a_n,
  output logic o_chip_sel_b,
  output logic o_chip_sel_c_n,
  // Write controls and output enable
  output logic o_global_write_n,
  output logic o_byte_write_enable_n,
  output logic [sram_pkg::LANES-1:0] o_byte_lane_select_n,
  output logic o_out_enable_n,
  // Data towards the pins
  output logic [sram_pkg::DATA_W-1:0] o_data,
  output logic [sram_pkg::LANES-1:0] o_parity_lines
);
  initial begin
    {o_processor_addr_strobe_n, o_controller_addr_strobe_n, o_burst_advance_n} = 3'h7;
    {o_global_write_n, o_byte_write_enable_n, o_out_enable_n, o_chip_sel_a_n} = 4'hF;
    o_chip_sel_b = 1'b0;
    o_chip_sel_c_n = 1'b0;
    o_byte_lane_select_n = 4'hF;
    o_addr = '0;
    {o_parity_lines, o_data} = 36'h0;
  end

  // ---------------------------------------------------------------
  // One bus cycle: ctl = strobe_p, strobe_c, sel_a, sel_b, oe request
  // ---------------------------------------------------------------
  task automatic go(input logic [4:0] ctl, input logic [sram_pkg::ADDR_W-1:0] a,
                    input logic [2:0] wc, input logic [3:0] ln, input logic [35:0] w);
    @(negedge i_sys_clk);
    {o_processor_addr_strobe_n, o_controller_addr_strobe_n} = ctl[4:3];
    {o_chip_sel_a_n, o_chip_sel_b} = ctl[2:1];
    o_addr = a;
    {o_burst_advance_n, o_global_write_n, o_byte_write_enable_n} = wc;
    o_byte_lane_select_n = ln;
    o_out_enable_n = ctl[0] | ~(wc[1] & wc[0]);
    // Idle data toggles so a stale value never looks valid
    {o_parity_lines, o_data} = o_out_enable_n ? w : ~{o_parity_lines, o_data};
    @(posedge i_sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_sys_clk;
  logic i_rst_b;
  logic strap;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [35:0] mem [int];
  wire [18:0] addr;
  wire processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
  wire chip_sel_a_n, chip_sel_b, chip_sel_c_n, global_write_n, byte_write_enable_n;
  wire out_enable_n, data_oe, parity_oe;
  wire [3:0] byte_lane_select_n, m_par, d_par;
  wire [31:0] m_data, d_data;
  wire [35:0] bus;
  // Shared pins: whoever is enabled owns the wire
  assign bus = data_oe ? {d_par, d_data} : {m_par, m_data};

  pipelined_burst_sram_access dut_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(addr),
    .i_processor_addr_strobe_n(processor_addr_strobe_n),
    .i_controller_addr_strobe_n(controller_addr_strobe_n), .i_burst_advance_n(burst_advance_n),
    .i_chip_sel_a_n(chip_sel_a_n), .i_chip_sel_b(chip_sel_b), .i_chip_sel_c_n(chip_sel_c_n),
    .i_global_write_n(global_write_n), .i_byte_write_enable_n(byte_write_enable_n),
    .i_byte_lane_select_n(byte_lane_select_n), .i_out_enable_n(out_enable_n),
    .i_burst_order(strap), .i_data(bus[31:0]), .o_data(d_data), .o_data_oe(data_oe),
    .i_parity_lines(bus[35:32]), .o_parity_lines(d_par), .o_parity_oe(parity_oe));

  bus_master_model m_u (.i_sys_clk(i_sys_clk), .o_addr(addr),
    .o_processor_addr_strobe_n(processor_addr_strobe_n),
    .o_controller_addr_strobe_n(controller_addr_strobe_n), .o_burst_advance_n(burst_advance_n),
    .o_chip_sel_a_n(chip_sel_a_n), .o_chip_sel_b(chip_sel_b), .o_chip_sel_c_n(chip_sel_c_n),
    .o_global_write_n(global_write_n), .o_byte_write_enable_n(byte_write_enable_n),
    .o_byte_lane_select_n(byte_lane_select_n), .o_out_enable_n(out_enable_n),
    .o_data(m_data), .o_parity_lines(m_par));

  // ---------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [35:0] g, input logic [35:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_word({35'h0, g}, {35'h0, e});
  endtask

  task automatic chk_off();
    chk_bit(data_oe, 1'b0);
    chk_bit(parity_oe, 1'b0);
  endtask

  task automatic chk_rd(input logic [18:0] a);
    chk_word({d_par, d_data}, mem[a]);
    chk_bit(data_oe, 1'b1);
    chk_bit(parity_oe, 1'b1);
  endtask

  // Address k steps into the burst from start a
  function automatic logic [18:0] ad(input logic [18:0] a, input int k);
    return {a[18:2], strap ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
  endfunction

  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] w,
                                        input logic [3:0] ln);
    logic [35:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      if (!ln[i]) begin
        m[8*i +: 8] = 8'hFF;
        m[32 + i] = 1'b1;
      end
    end
    return (o & ~m) | (w & m);
  endfunction

  // ---------------------------------------------------------------
  // Bus cycles and scenarios
  // ---------------------------------------------------------------
  task automatic st(input logic [1:0] stb, input logic [18:0] a, input logic [2:0] wc);
    m_u.go({stb, 3'h2}, a, wc, 4'hF, 36'h0);
  endtask

  task automatic rd(input logic adv_n, input logic oe_n);
    m_u.go({4'hD, oe_n}, '1, {adv_n, 2'h3}, 4'hF, 36'h0);
  endtask

  task automatic wr(input logic [2:0] wc, input logic [3:0] ln, input logic [35:0] w);
    m_u.go(5'h1A, '1, wc, ln, w);
  endtask

  task automatic desel();
    m_u.go(5'h08, '0, 3'h7, 4'hF, 36'h0);
    chk_off();
  endtask

  task automatic do_reset(input logic v);
    @(negedge i_sys_clk);
    i_rst_b = 1'b0;
    strap = v;
    repeat (8) @(negedge i_sys_clk);
    i_rst_b = 1'b1;
  endtask

  task automatic t_fill(input logic [18:0] a);
    logic [35:0] w;
    st(2'h1, a, 3'h7);
    for (int k = 0; k < 4; k++) begin
      w = {4'h9 ^ 4'(k), 13'h1ABC, ad(a, k)};
      mem[ad(a, k)] = w;
      wr(3'h1, 4'hF, w);
      chk_off();
    end
    desel();
  endtask

  task automatic t_read(input logic [18:0] a, input logic [1:0] stb, input logic [2:0] wc);
    st(stb, a, wc);
    chk_off();
    rd(1'b1, 1'b0);
    chk_rd(ad(a, 0));
    for (int k = 0; k < 5; k++) begin
      rd(1'b0, 1'b0);
      chk_rd(ad(a, k));
    end
    rd(1'b1, 1'b0);
    chk_rd(ad(a, 5));
    rd(1'b1, 1'b1);
    chk_off();
    rd(1'b1, 1'b0);
    chk_rd(ad(a, 5));
    m_u.go(5'h0E, a ^ 19'h4, 3'h7, 4'hF, 36'h0);
    rd(1'b1, 1'b0);
    chk_rd(ad(a, 5));
    m_u.go(5'h16, '0, 3'h7, 4'hF, 36'h0);
    chk_off();
    // Processor strobe with select A high must not wake the device
    m_u.go(5'h0E, a, 3'h7, 4'hF, 36'h0);
    rd(1'b1, 1'b0);
    chk_off();
  endtask

  // Controller start lets advance count from the second edge
  task automatic t_burst(input logic [18:0] a);
    st(2'h2, a, 3'h7);
    for (int k = 0; k < 4; k++) begin
      rd(1'b0, 1'b0);
      chk_rd(ad(a, k));
    end
    rd(1'b1, 1'b0);
    chk_rd(ad(a, 4));
    desel();
  endtask

  task automatic t_bytes(input logic [18:0] a);
    logic [35:0] w;
    w = 36'h5A5A5A5A5;
    st(2'h1, a, 3'h7);
    wr(3'h2, 4'h9, w);
    mem[ad(a, 0)] = merge(mem[ad(a, 0)], w, 4'h9);
    chk_off();
    wr(3'h3, 4'h0, ~w);
    wr(3'h0, 4'hE, ~w);
    mem[ad(a, 2)] = ~w;
    chk_off();
    desel();
  endtask

  initial begin
    i_rst_b = 1'b0;
    strap = 1'b0;
    do_reset(1'b0);
    t_fill(19'h2A5C7);
    t_read(19'h2A5C7, 2'h1, 3'h7);
    t_read(19'h2A5C7, 2'h2, 3'h7);
    t_bytes(19'h2A5C7);
    t_read(19'h2A5C7, 2'h0, 3'h0);
    t_burst(19'h2A5C7);
    do_reset(1'b1);
    t_fill(19'h4C3D2);
    t_read(19'h4C3D2, 2'h1, 3'h7);
    t_burst(19'h4C3D2);
    final_report();
  end
endmodule
`default_nettype wire
